// ### apr_pkg.sv
// Package with pin timing, address layout and command codes for the memory port controller
package apr_pkg;
  // Core clock period
  localparam int CLK_PERIOD_NS = 40;
  // Device timing figures in their own units
  localparam int READ_CYCLE_NS = 70;
  localparam int PAGE_CYCLE_NS = 20;
  localparam int WRITE_PULSE_NS = 70;
  localparam int DATA_SETUP_NS = 20;
  localparam int CS_HIGH_NS = 10;
  localparam int CFG_SETUP_NS = 10;
  localparam int CFG_SETUP_MAX_NS = 500;
  localparam int CS_TO_CFG_NS = 5;
  localparam int CS_LOW_LIMIT_US = 10;
  // Cycle counts: least times round up, longest times round down
  function automatic int ceil_cyc(input int ns);
    ceil_cyc = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (ceil_cyc < 1) ceil_cyc = 1;
  endfunction
  localparam int READ_CYC = ceil_cyc(READ_CYCLE_NS);
  localparam int PAGE_CYC = ceil_cyc(PAGE_CYCLE_NS);
  localparam int WRITE_CYC = ceil_cyc(WRITE_PULSE_NS);
  localparam int CS_HIGH_CYC = ceil_cyc(CS_HIGH_NS);
  localparam int CFG_SETUP_CYC = ceil_cyc(CFG_SETUP_NS);
  localparam int CS_TO_CFG_CYC = ceil_cyc(CS_TO_CFG_NS);
  localparam int CS_LOW_LIMIT_CYC = (CS_LOW_LIMIT_US * 1000) / CLK_PERIOD_NS;
  // Address layout
  localparam int ADDR_W = 21;
  localparam int PAGE_LSB = 4;
  localparam int PAGE_MSB = 18;
  localparam int TOP_ADDR_BIT = 20;
  localparam int DATA_W = 16;
  // Page enable bit in the refresh configuration word
  localparam int CFG_PAGE_BIT = 7;
  // Host commands
  typedef enum logic [1:0] {APR_CMD_READ, APR_CMD_WRITE, APR_CMD_CFG} apr_cmd_e;
  localparam logic [3:0] TIMER_ZERO = 4'h0;
endpackage

// ### apr_pins_if.sv
// Interface carrying the memory pin group between the sequencer and the pin register
`timescale 1ns/1ps
interface apr_pins_if;
  logic        cs_n;
  logic        oe_n;
  logic        we_n;
  logic        ub_n;
  logic        lb_n;
  logic        cfg_n;
  logic [20:0] addr;
  logic [15:0] dout;
  logic        dout_en;
  modport seq (output cs_n, oe_n, we_n, ub_n, lb_n, cfg_n, addr, dout, dout_en);
  modport pin (input cs_n, oe_n, we_n, ub_n, lb_n, cfg_n, addr, dout, dout_en);
endinterface

// ### apr_pin_reg.sv
// Output flip-flops for every memory pin, so pins never glitch
`timescale 1ns/1ps
module apr_pin_reg (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // From sequencer
  apr_pins_if.pin          pins,
  // Device pins
  output logic             chip_select_n,
  output logic             output_enable_n,
  output logic             write_enable_n,
  output logic             upper_byte_enable_n,
  output logic             lower_byte_enable_n,
  output logic             sleep_config_n,
  output logic [20:0]      mem_addr,
  output logic [15:0]      data_io_out,
  output logic             data_io_oe
);
  typedef struct packed {
    logic        cs_n, oe_n, we_n, ub_n, lb_n, cfg_n;
    logic [20:0] addr;
    logic [15:0] dout;
    logic        den;
  } apr_pin_s;
  apr_pin_s st_q, st_d;

  // Copy the requested pin levels
  always_comb begin
    st_d = '{pins.cs_n, pins.oe_n, pins.we_n, pins.ub_n, pins.lb_n, pins.cfg_n,
             pins.addr, pins.dout, pins.dout_en};
  end

  // Idle bus after reset: all strobes high, bus released
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_q <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 21'h00_0000, 16'h0000, 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign chip_select_n       = st_q.cs_n;
  assign output_enable_n     = st_q.oe_n;
  assign write_enable_n      = st_q.we_n;
  assign upper_byte_enable_n = st_q.ub_n;
  assign lower_byte_enable_n = st_q.lb_n;
  assign sleep_config_n      = st_q.cfg_n;
  assign mem_addr            = st_q.addr;
  assign data_io_out         = st_q.dout;
  assign data_io_oe          = st_q.den;
endmodule

// ### apr_ctrl.sv
// Host-side controller driving an asynchronous page-capable pseudo-static memory
`timescale 1ns/1ps
module apr_ctrl #(
  parameter int CS_LOW_LIMIT = apr_pkg::CS_LOW_LIMIT_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Host request
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [1:0]  req_cmd,
  input  wire logic [20:0] req_addr,
  input  wire logic [15:0] req_wdata,
  input  wire logic [1:0]  req_byte_en,
  // Read answer
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata,
  // Status
  output logic             page_mode_on,
  // Device pins
  output logic             chip_select_n,
  output logic             output_enable_n,
  output logic             write_enable_n,
  output logic             upper_byte_enable_n,
  output logic             lower_byte_enable_n,
  output logic             sleep_config_n,
  output logic [20:0]      mem_addr,
  output logic [15:0]      data_io_out,
  output logic             data_io_oe,
  input  wire logic [15:0] data_io_in
);
  // A limit shorter than one random read plus the page close cannot be met
  if (CS_LOW_LIMIT < apr_pkg::READ_CYC + 4) begin : g_bad_limit
    $error("CS_LOW_LIMIT too small");
  end

  typedef enum logic [2:0] {
    S_IDLE, S_READ, S_PAGE, S_HOLD, S_WRITE, S_CFG_SET, S_GAP, S_CS_WAIT
  } apr_state_e;

  typedef struct packed {
    apr_state_e  state;
    logic [3:0]  tmr;
    logic [31:0] cs_low_cnt;
    logic        cs_n, oe_n, we_n, cfg_n;
    logic [1:0]  ben_n;
    logic [20:0] addr;
    logic [15:0] wdata;
    logic        den;
    logic        open_page;
    logic        page_en;
    logic        rsp;
    logic [15:0] rdata;
  } apr_ctl_s;

  apr_ctl_s   s_q, s_d;
  apr_pins_if pins ();

  // Same page when bits 18 to 4 match; the low nibble and bit 19 may differ
  function automatic logic same_page(input logic [20:0] a, input logic [20:0] b);
    same_page = a[apr_pkg::PAGE_MSB:apr_pkg::PAGE_LSB] == b[apr_pkg::PAGE_MSB:apr_pkg::PAGE_LSB];
  endfunction

  // Address with the unused top bit forced low
  function automatic logic [20:0] clean_addr(input logic [20:0] a);
    clean_addr = a;
    clean_addr[apr_pkg::TOP_ADDR_BIT] = 1'b0;
  endfunction

  // Lane data kept only where the byte enable was active
  function automatic logic [15:0] lane_mask(input logic [15:0] d, input logic [1:0] bn);
    lane_mask = {bn[1] ? 8'h00 : d[15:8], bn[0] ? 8'h00 : d[7:0]};
  endfunction

  logic [1:0] ben_n_req;
  logic       page_hit;
  logic       cs_over;

  assign ben_n_req = ~req_byte_en;
  // A page hit needs page mode, an open read, matching bits 18 to 4 and a read request
  assign page_hit  = s_q.open_page && s_q.page_en && (req_cmd == 2'(apr_pkg::APR_CMD_READ))
                     && same_page(s_q.addr, clean_addr(req_addr));
  assign cs_over   = s_q.cs_low_cnt >= 32'(CS_LOW_LIMIT - apr_pkg::PAGE_CYC - 2);
  // Ready only where the request is served at once; a page close must not swallow it
  assign req_ready = (s_q.state == S_IDLE)
                     || (s_q.state == S_HOLD && page_hit && !cs_over);

  // Sequencer: one request at a time, strobes paced by the timer
  always_comb begin
    s_d     = s_q;
    s_d.rsp = 1'b0;
    if (s_q.tmr != apr_pkg::TIMER_ZERO) s_d.tmr = s_q.tmr - 4'h1;
    // Count chip select low time in every state; chip select high clears the count
    s_d.cs_low_cnt = s_q.cs_n ? 32'h0000_0000 : s_q.cs_low_cnt + 32'h0000_0001;
    case (s_q.state)
      S_IDLE, S_HOLD: begin
        if (s_q.state == S_HOLD && (cs_over || (req_valid && !page_hit))) begin
          // Close the page: toggle chip select high before anything else
          s_d.cs_n = 1'b1;
          s_d.oe_n = 1'b1;
          s_d.ben_n = 2'b11;
          s_d.open_page = 1'b0;
          s_d.tmr = 4'(apr_pkg::CS_HIGH_CYC);
          s_d.state = S_GAP;
        end else if (req_valid && page_hit) begin
          // Only the low nibble and bit 19 can move; page access time suffices
          s_d.addr = clean_addr(req_addr);
          s_d.ben_n = ben_n_req;
          s_d.tmr = 4'(apr_pkg::PAGE_CYC);
          s_d.state = S_PAGE;
        end else if (req_valid && s_q.state == S_IDLE) begin
          s_d.addr = clean_addr(req_addr);
          s_d.ben_n = ben_n_req;
          s_d.wdata = req_wdata;
          if (req_cmd == 2'(apr_pkg::APR_CMD_READ)) begin
            s_d.cs_n = 1'b0;
            s_d.oe_n = 1'b0;
            s_d.we_n = 1'b1;
            s_d.tmr = 4'(apr_pkg::READ_CYC);
            s_d.state = S_READ;
          end else if (req_cmd == 2'(apr_pkg::APR_CMD_CFG)) begin
            // Chip select already high for the gap; now drop the config pin
            s_d.cfg_n = 1'b0;
            s_d.oe_n = 1'b1;
            s_d.tmr = 4'(apr_pkg::CFG_SETUP_CYC);
            s_d.state = S_CFG_SET;
          end else begin
            // Full write cycle; address, data and strobes move together
            s_d.cs_n = 1'b0;
            s_d.we_n = 1'b0;
            s_d.oe_n = 1'b1;
            s_d.den = 1'b1;
            s_d.tmr = 4'(apr_pkg::WRITE_CYC);
            s_d.state = S_WRITE;
          end
        end
      end
      S_READ, S_PAGE: begin
        if (s_q.tmr == apr_pkg::TIMER_ZERO) begin
          s_d.rdata = lane_mask(data_io_in, s_q.ben_n);
          s_d.rsp = 1'b1;
          s_d.open_page = 1'b1;
          s_d.state = S_HOLD;
        end
      end
      S_CFG_SET: begin
        if (s_q.tmr == apr_pkg::TIMER_ZERO) begin
          // Setup met well inside the 500 ns ceiling
          s_d.cs_n = 1'b0;
          s_d.we_n = 1'b0;
          s_d.den = 1'b1;
          s_d.tmr = 4'(apr_pkg::WRITE_CYC);
          s_d.state = S_WRITE;
        end
      end
      S_WRITE: begin
        if (s_q.tmr == apr_pkg::TIMER_ZERO) begin
          // All strobes rise together; data and config pin still held this edge
          s_d.cs_n = 1'b1;
          s_d.we_n = 1'b1;
          s_d.ben_n = 2'b11;
          s_d.tmr = 4'(apr_pkg::CS_HIGH_CYC);
          s_d.state = S_CS_WAIT;
        end
      end
      S_CS_WAIT: begin
        // Drop drive and config pin one edge after the strobes rose
        s_d.den = 1'b0;
        s_d.cfg_n = 1'b1;
        if (s_q.cfg_n == 1'b0) s_d.page_en = s_q.wdata[apr_pkg::CFG_PAGE_BIT];
        s_d.state = S_GAP;
      end
      S_GAP: begin
        if (s_q.tmr == apr_pkg::TIMER_ZERO) s_d.state = S_IDLE;
      end
      default: s_d.state = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_q <= '{S_IDLE, 4'h0, 32'h0000_0000, 1'b1, 1'b1, 1'b1, 1'b1, 2'b11,
               21'h00_0000, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000};
    end else begin
      s_q <= s_d;
    end
  end

  // Hand pin levels to the pin register
  assign pins.cs_n    = s_d.cs_n;
  assign pins.oe_n    = s_d.oe_n;
  assign pins.we_n    = s_d.we_n;
  assign pins.ub_n    = s_d.ben_n[1];
  assign pins.lb_n    = s_d.ben_n[0];
  assign pins.cfg_n   = s_d.cfg_n;
  assign pins.addr    = s_d.addr;
  assign pins.dout    = s_d.wdata;
  assign pins.dout_en = s_d.den;

  apr_pin_reg u_pins (
    .core_clk            (core_clk),
    .resetn              (resetn),
    .pins                (pins),
    .chip_select_n       (chip_select_n),
    .output_enable_n     (output_enable_n),
    .write_enable_n      (write_enable_n),
    .upper_byte_enable_n (upper_byte_enable_n),
    .lower_byte_enable_n (lower_byte_enable_n),
    .sleep_config_n      (sleep_config_n),
    .mem_addr            (mem_addr),
    .data_io_out         (data_io_out),
    .data_io_oe          (data_io_oe)
  );

  assign rsp_valid    = s_q.rsp;
  assign rsp_rdata    = s_q.rdata;
  assign page_mode_on = s_q.page_en;
endmodule

// ### apr_monitor.sv
// Checker of the controller's pin sequencing, bound to the controller module apr_ctrl
`timescale 1ns/1ps
module apr_monitor #(
  parameter int CS_LOW_LIMIT = apr_pkg::CS_LOW_LIMIT_CYC
) (
  // Clock, reset and status
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        rsp_valid,
  input wire logic        page_mode_on,
  // Device pins
  input wire logic        chip_select_n,
  input wire logic        output_enable_n,
  input wire logic        write_enable_n,
  input wire logic        sleep_config_n,
  input wire logic [20:0] mem_addr,
  input wire logic [15:0] data_io_out,
  input wire logic        data_io_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  int cs_low_q;
  // Run length of chip select low; an int cannot wrap within a run
  always_ff @(posedge core_clk) begin
    if (!resetn || chip_select_n) cs_low_q <= 0;
    else cs_low_q <= cs_low_q + 1;
  end
  // Write strobe held long enough for address and data set-up
  sequence wr_pulse;
    !write_enable_n [*2];
  endsequence
  // Answer no sooner than the random access time allows
  sequence rd_answer;
    !rsp_valid [*2] ##[1:4] rsp_valid;
  endsequence
  top_addr_a: assert property (!mem_addr[20]) else $error("top address bit high");
  read_pins_a: assert property (
    !output_enable_n && !chip_select_n |-> write_enable_n && !data_io_oe)
    else $error("read with write strobe or bus driven");
  write_pins_a: assert property (!write_enable_n |-> !chip_select_n && data_io_oe)
    else $error("write without select or data");
  write_len_a: assert property ($fell(write_enable_n) |-> wr_pulse)
    else $error("write pulse too short");
  write_hold_a: assert property (
    !write_enable_n && $past(!write_enable_n) |-> $stable(mem_addr) && $stable(data_io_out))
    else $error("address or data moved in write");
  cfg_setup_a: assert property ($fell(sleep_config_n) |->
    (chip_select_n && $past(chip_select_n)) ##[1:12] $fell(write_enable_n))
    else $error("config pin set-up broken");
  cfg_hold_a: assert property (
    $rose(sleep_config_n) |-> write_enable_n && $past(write_enable_n))
    else $error("config pin released in write");
  cfg_close_a: assert property (
    $rose(write_enable_n) && !sleep_config_n |-> chip_select_n)
    else $error("select not toggled after config");
  page_only_a: assert property (
    !chip_select_n && $past(!chip_select_n) && $changed(mem_addr) |->
    page_mode_on && write_enable_n && mem_addr[19:4] == $past(mem_addr[19:4]))
    else $error("address moved outside a page read");
  cs_limit_a: assert property (page_mode_on |-> cs_low_q <= CS_LOW_LIMIT + 1)
    else $error("select held low too long");
  read_time_a: assert property ($fell(chip_select_n) && !output_enable_n |-> rd_answer)
    else $error("read answer out of time");
endmodule
bind apr_ctrl apr_monitor #(.CS_LOW_LIMIT(CS_LOW_LIMIT)) u_mon (.core_clk, .resetn,
  .rsp_valid, .page_mode_on, .chip_select_n, .output_enable_n, .write_enable_n,
  .sleep_config_n, .mem_addr, .data_io_out, .data_io_oe);

// ### apr_mem_model.sv
// Behavioural pseudo-static memory answering the controller's pins
`timescale 1ns/1ps
module apr_mem_model (
  // Device pins
  input  wire logic        chip_select_n,
  input  wire logic        output_enable_n,
  input  wire logic        write_enable_n,
  input  wire logic        upper_byte_enable_n,
  input  wire logic        lower_byte_enable_n,
  input  wire logic        sleep_config_n,
  input  wire logic [20:0] mem_addr,
  input  wire logic [15:0] data_io_out,
  output logic      [15:0] data_io_in
);
  logic [15:0] mem [0:1023];
  logic [15:0] cfg_q = 16'h0000;
  logic [15:0] last_q = 16'h0000;
  logic [1:0]  lanes_q;
  logic [19:0] full_q;
  logic [19:0] fast_q;
  logic        rd_on;
  logic        wr_on;
  logic        ready;
  logic [15:0] word;
  assign rd_on = !chip_select_n && !output_enable_n && write_enable_n;
  assign wr_on = !chip_select_n && !write_enable_n;
  // Addresses seen after the access times; only asynchronous mode exists here
  always @(mem_addr) begin
    full_q <= #70 mem_addr[19:0];
    fast_q <= #20 mem_addr[19:0];
  end
  assign ready = full_q == mem_addr[19:0] || (cfg_q[7] &&
    full_q[19:4] == mem_addr[19:4] && fast_q == mem_addr[19:0]);
  assign word = ready ? mem[mem_addr[9:0]] : ~last_q;
  // Lanes not driven show the inverse of the last word, never a friendly value
  assign data_io_in = !rd_on ? ~last_q :
    {upper_byte_enable_n ? ~last_q[15:8] : word[15:8],
     lower_byte_enable_n ? ~last_q[7:0] : word[7:0]};
  always @(negedge rd_on) last_q = word;
  // Lanes sampled just after the pulse opens, so same-edge pin updates cannot race
  always @(posedge wr_on) begin
    #1;
    lanes_q = {!upper_byte_enable_n, !lower_byte_enable_n};
  end
  // Commit on the first strobe to rise; config pin low selects the register
  always @(negedge wr_on) begin
    if (!sleep_config_n) cfg_q = data_io_out;
    else begin
      if (lanes_q[1]) mem[mem_addr[9:0]][15:8] = data_io_out[15:8];
      if (lanes_q[0]) mem[mem_addr[9:0]][7:0] = data_io_out[7:0];
    end
  end
endmodule

// ### tb_top.sv
// Self-checking bench for the memory port controller
`timescale 1ns/1ps
module tb_top;
  localparam int LIMIT = 16;
  logic        core_clk, resetn, req_valid, req_ready, rsp_valid, page_mode_on;
  logic [1:0]  req_cmd, req_byte_en;
  logic [20:0] req_addr, mem_addr;
  logic [15:0] req_wdata, rsp_rdata, data_io_out, data_io_in;
  logic        chip_select_n, output_enable_n, write_enable_n, data_io_oe;
  logic        upper_byte_enable_n, lower_byte_enable_n, sleep_config_n;
  int          mismatches;
  int          checks;
  int          cycles;
  apr_ctrl #(.CS_LOW_LIMIT(LIMIT)) u_dut (.core_clk, .resetn, .req_valid, .req_ready,
    .req_cmd, .req_addr, .req_wdata, .req_byte_en, .rsp_valid, .rsp_rdata, .page_mode_on,
    .chip_select_n, .output_enable_n, .write_enable_n, .upper_byte_enable_n,
    .lower_byte_enable_n, .sleep_config_n, .mem_addr, .data_io_out, .data_io_oe,
    .data_io_in);
  apr_mem_model u_mem (.chip_select_n, .output_enable_n, .write_enable_n,
    .upper_byte_enable_n, .lower_byte_enable_n, .sleep_config_n, .mem_addr,
    .data_io_out, .data_io_in);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Hang guard; the planned run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic check(input logic [20:0] seen, input logic [20:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // A clear edge before raising valid, so two requests never meet in one step
  task automatic send(input logic [1:0] c, input logic [20:0] a, input logic [15:0] d,
                      input logic [1:0] be);
    @(negedge core_clk);
    req_cmd = c;
    req_addr = a;
    req_wdata = d;
    req_byte_en = be;
    req_valid = 1'b1;
    @(posedge core_clk);
    while (req_ready !== 1'b1) @(posedge core_clk);
    @(negedge core_clk);
    req_valid = 1'b0;
  endtask
  task automatic wr(input logic [20:0] a, input logic [15:0] d, input logic [1:0] be);
    send(apr_pkg::APR_CMD_WRITE, a, d, be);
  endtask
  // Read, count falling edges until the answer and compare it
  task automatic rd(input logic [20:0] a, input logic [1:0] be, input logic [15:0] e,
                    output int lat);
    send(apr_pkg::APR_CMD_READ, a, 16'h0000, be);
    lat = 0;
    while (rsp_valid !== 1'b1) begin
      @(negedge core_clk);
      lat++;
    end
    check(21'(rsp_rdata), 21'(e));
  endtask
  task automatic t_lanes();
    int lat;
    wr(21'h00_0020, 16'h1234, 2'b11);
    wr(21'h00_0020, 16'hab00, 2'b10);
    wr(21'h10_0020, 16'hffff, 2'b00);
    rd(21'h10_0020, 2'b11, 16'hab34, lat);
    rd(21'h00_0020, 2'b01, 16'h0034, lat);
    rd(21'h00_0020, 2'b10, 16'hab00, lat);
    $display("test lanes done");
  endtask
  task automatic t_page();
    int lat;
    int lat_r;
    int lat_p;
    lat_p = 99;
    send(apr_pkg::APR_CMD_CFG, 21'h00_0000, 16'h0080, 2'b11);
    for (int i = 0; i < 16; i++) wr(21'(i + 64), 16'(i + 23040), 2'b11);
    check(21'(page_mode_on), 21'h00_0001);
    rd(21'h00_0040, 2'b11, 16'h5a00, lat_r);
    // Long page run also forces the select low limit with the small count
    for (int i = 1; i < 16; i++) begin
      rd(21'(i + 64), 2'b11, 16'(i + 23040), lat);
      if (lat < lat_p) lat_p = lat;
    end
    check(21'(lat_p < lat_r), 21'h00_0001);
    rd(21'h00_0020, 2'b11, 16'hab34, lat);
    check(21'(lat > lat_p), 21'h00_0001);
    $display("test page done");
  endtask
  task automatic t_page_off();
    int lat;
    int lat2;
    send(apr_pkg::APR_CMD_CFG, 21'h00_0000, 16'h0000, 2'b11);
    rd(21'h00_0041, 2'b11, 16'h5a01, lat);
    rd(21'h00_0042, 2'b11, 16'h5a02, lat2);
    check(21'(page_mode_on), 21'h00_0000);
    check(21'(lat2), 21'(lat));
    $display("test page off done");
  endtask
  initial begin
    resetn = 1'b0;
    req_valid = 1'b0;
    req_cmd = 2'b00;
    req_addr = 21'h00_0000;
    req_wdata = 16'h0000;
    req_byte_en = 2'b00;
    repeat (6) @(negedge core_clk);
    check(21'({chip_select_n, write_enable_n, sleep_config_n, page_mode_on}),
          21'h00_000e);
    resetn = 1'b1;
    $display("test reset done");
    t_lanes();
    t_page();
    t_page_off();
    stop_test();
  end
endmodule
